// File: common/cfs_defines.vh
// Purpose: constants for the fetch sequencer and its register port
// Assumes: included by hdl/cfs_sequencer.v only
// Notes:   offsets are byte addresses on the register bus
`ifndef CFS_DEFINES_VH
`define CFS_DEFINES_VH

// register bus map
`define CFS_OFF_CTRL     8'h00
`define CFS_OFF_PM_ADDR  8'h04
`define CFS_OFF_PM_DATA  8'h08
`define CFS_OFF_STATE    8'h0C
`define CFS_OFF_CORE     8'h10
`define CFS_CTRL_RUN     0
`define CFS_CTRL_RESTART 1

// vectors
`define CFS_VEC_RESET    11'h000
`define CFS_VEC_INT      11'h004

// stack
`define CFS_STACK_LEVELS 3'h4

// instruction classes, bits 14:11
`define CFS_OP_MISC      4'h0
`define CFS_OP_ALUA      4'h1
`define CFS_OP_ALUM      4'h2
`define CFS_OP_SKIP      4'h3
`define CFS_OP_MOVI      4'h5
`define CFS_OP_JUMP      4'h6
`define CFS_OP_CALL      4'h7
`define CFS_OP_TABRD     4'h8
`define CFS_NOP          15'h0000

// misc sub-codes, bits 10:7
`define CFS_MS_RET       4'h1
`define CFS_MS_INTERRUPT_EXIT      4'h2
`define CFS_MS_EI        4'h3
`define CFS_MS_DI        4'h4

// alu functions, bits 10:7
`define CFS_FN_ADD       4'h0
`define CFS_FN_ADC       4'h1
`define CFS_FN_SUB       4'h2
`define CFS_FN_SBC       4'h3
`define CFS_FN_AND       4'h4
`define CFS_FN_OR        4'h5
`define CFS_FN_XOR       4'h6
`define CFS_FN_CPL       4'h7
`define CFS_FN_RR        4'h8
`define CFS_FN_RRC       4'h9
`define CFS_FN_RL        4'hA
`define CFS_FN_RLC       4'hB
`define CFS_FN_INC       4'hC
`define CFS_FN_DEC       4'hD
`define CFS_FN_DAA       4'hE
`define CFS_FN_PASS      4'hF

// skip sub-codes
`define CFS_SK_SZ        4'h0
`define CFS_SK_SNZ       4'h1
`define CFS_SK_SIZ       4'h2
`define CFS_SK_SDZ       4'h3
`define CFS_SK_SIZA      4'h4
`define CFS_SK_SDZA      4'h5
`define CFS_SK_SZA       4'h6

// special data memory addresses
`define CFS_DM_ACC       7'h05
`define CFS_DM_PCL       7'h06
`define CFS_DM_TBLP      7'h07
`define CFS_DM_LOOKUP_HIGH_BYTE      7'h08
`define CFS_DM_LOOKUP_POINTER_HIGH      7'h09
`define CFS_DM_STATUS    7'h0A

// status bits
`define CFS_ST_C         0
`define CFS_ST_AC        1
`define CFS_ST_Z         2
`define CFS_ST_OV        3
`endif

// File: hdl/cfs_sequencer.v
// Purpose: four-phase fetch/execute sequencer with pc, stack, alu, table read
// Assumes: all inputs synchronous to clk; program loaded over the register bus
// Notes:   one phase per clk while running; execution commits in the fourth phase
`timescale 1ns/1ps
`include "cfs_defines.vh"

module cfs_sequencer (
  // clock and reset
  input  wire        clk,
  input  wire        nrst,
  // register bus
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // interrupt handshake
  input  wire        intReq,
  output reg         intAck,
  // phase view
  output reg  [3:0]  cyclePhases
);

  // program and data memories
  reg  [14:0] progMem [0:2047];
  reg  [7:0]  dataMem [0:127];

  // bus side state
  reg         runEn;
  reg         restart;
  reg  [10:0] pmAddr;

  // sequencer state
  reg  [1:0]  phase;
  reg  [10:0] pc;
  reg  [14:0] fetchIr;
  reg  [14:0] execIr;
  reg         flush;
  reg         hold;
  reg  [6:0]  tblDest;
  reg         tblLast;
  reg  [2:0]  depth;
  reg  [7:0]  acc;
  reg  [3:0]  status;
  reg  [7:0]  tblp;
  reg  [2:0]  lookup_pointer_high;
  reg  [6:0]  lookupHigh;
  reg         intEnable;
  reg         intFlag;

  // decode results
  reg  [3:0]  opc;
  reg  [3:0]  fn;
  reg  [6:0]  ma;
  reg  [7:0]  memVal;
  reg  [7:0]  aluB;
  reg  [7:0]  sumX;
  reg         sumCi;
  reg  [8:0]  sum9;
  reg  [4:0]  sumLo;
  reg  [8:0]  daaT;
  reg  [8:0]  daaR;
  reg  [7:0]  aluRes;
  reg  [3:0]  aluFlags;
  reg  [3:0]  aluMask;
  reg  [7:0]  stepVal;
  reg         wrEn;
  reg  [6:0]  wrAddr;
  reg  [7:0]  wrData;
  reg         accEn;
  reg  [7:0]  accData;
  reg  [3:0]  flagMask;
  reg         pcLoad;
  reg  [10:0] pcTarget;
  reg         flushReq;
  reg         push;
  reg         pop;
  reg         holdSet;
  reg         intEnSet;
  reg         intEnClr;

  wire        doStep   = runEn & ~restart;
  wire        doExec   = doStep & (phase == 2'h3);
  wire        doFetch  = doStep & (phase == 2'h0);
  wire [10:0] pcNext   = pc - 11'h001;
  wire [10:0] tblAddr  = tblLast ? {3'h7, tblp} : {lookup_pointer_high, tblp};
  wire [14:0] tblWord  = progMem[tblAddr];
  wire        stackFull = (depth == `CFS_STACK_LEVELS);
  wire        ackNow   = doExec & intFlag & intEnable & ~stackFull & ~hold & ~holdSet
                         & ~flushReq & ~push & ~pop;
  wire        busWr    = psel & penable & pready & pwrite;
  wire        busSetup = psel & ~penable;

  // stack levels: slot0 push value, slot1..4 levels, slot5 zero fill
  wire [65:0] stackChain;
  assign stackChain[10:0]  = pcNext;
  assign stackChain[65:55] = 11'h000;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : stackLevel
      reg [10:0] entry;
      assign stackChain[(gi+1)*11 +: 11] = entry;
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          entry <= 11'h000;
        end else if (doExec && (push || ackNow)) begin
          entry <= stackChain[gi*11 +: 11];
        end else if (doExec && pop) begin
          entry <= stackChain[(gi+2)*11 +: 11];
        end
      end
    end
  endgenerate

  // operand fetch, alu and decode
  always @* begin
    opc = execIr[14:11];
    fn  = execIr[10:7];
    ma  = execIr[6:0];
    case (ma)
      `CFS_DM_ACC:    memVal = acc;
      `CFS_DM_PCL:    memVal = pcNext[7:0];
      `CFS_DM_TBLP:   memVal = tblp;
      `CFS_DM_LOOKUP_HIGH_BYTE:   memVal = {1'b0, lookupHigh};
      `CFS_DM_LOOKUP_POINTER_HIGH:   memVal = {5'h00, lookup_pointer_high};
      `CFS_DM_STATUS: memVal = {4'h0, status};
      default:        memVal = dataMem[ma];
    endcase
    aluB  = (opc == `CFS_OP_ALUM && fn == `CFS_FN_PASS) ? acc : memVal;
    sumX  = (fn == `CFS_FN_SUB || fn == `CFS_FN_SBC) ? ~aluB : aluB;
    sumCi = (fn == `CFS_FN_SUB) ? 1'b1 :
            (fn == `CFS_FN_ADD) ? 1'b0 : status[`CFS_ST_C];
    sum9  = {1'b0, acc} + {1'b0, sumX} + {8'h00, sumCi};
    sumLo = {1'b0, acc[3:0]} + {1'b0, sumX[3:0]} + {4'h0, sumCi};
    daaT  = {1'b0, acc} + (((acc[3:0] > 4'h9) || status[`CFS_ST_AC]) ? 9'h006 : 9'h000);
    daaR  = daaT + ((daaT[8] || status[`CFS_ST_C] || (daaT[7:4] > 4'h9)) ?
            9'h060 : 9'h000);
    aluFlags = 4'h0;
    aluMask  = 4'h0;
    aluRes   = aluB;
    case (fn)
      `CFS_FN_ADD, `CFS_FN_ADC, `CFS_FN_SUB, `CFS_FN_SBC: begin
        aluRes = sum9[7:0];
        aluFlags[`CFS_ST_C]  = sum9[8];
        aluFlags[`CFS_ST_AC] = sumLo[4];
        aluFlags[`CFS_ST_OV] = (acc[7] == sumX[7]) && (sum9[7] != acc[7]);
        aluMask = 4'hF;
      end
      `CFS_FN_AND: begin
        aluRes = acc & aluB;
        aluMask = 4'h4;
      end
      `CFS_FN_OR: begin
        aluRes = acc | aluB;
        aluMask = 4'h4;
      end
      `CFS_FN_XOR: begin
        aluRes = acc ^ aluB;
        aluMask = 4'h4;
      end
      `CFS_FN_CPL: begin
        aluRes = ~aluB;
        aluMask = 4'h4;
      end
      `CFS_FN_RR:  aluRes = {aluB[0], aluB[7:1]};
      `CFS_FN_RRC: begin
        aluRes = {status[`CFS_ST_C], aluB[7:1]};
        aluFlags[`CFS_ST_C] = aluB[0];
        aluMask = 4'h1;
      end
      `CFS_FN_RL:  aluRes = {aluB[6:0], aluB[7]};
      `CFS_FN_RLC: begin
        aluRes = {aluB[6:0], status[`CFS_ST_C]};
        aluFlags[`CFS_ST_C] = aluB[7];
        aluMask = 4'h1;
      end
      `CFS_FN_INC: begin
        aluRes = aluB + 8'h01;
        aluMask = 4'h4;
      end
      `CFS_FN_DEC: begin
        aluRes = aluB - 8'h01;
        aluMask = 4'h4;
      end
      `CFS_FN_DAA: begin
        aluRes = daaR[7:0];
        aluFlags[`CFS_ST_C] = daaR[8] | daaT[8] | status[`CFS_ST_C];
        aluMask = 4'h1;
      end
      default: aluRes = aluB;
    endcase
    aluFlags[`CFS_ST_Z] = (aluRes == 8'h00);
    stepVal = (fn == `CFS_SK_SIZ || fn == `CFS_SK_SIZA) ? memVal + 8'h01 :
              (fn == `CFS_SK_SDZ || fn == `CFS_SK_SDZA) ? memVal - 8'h01 : memVal;

    wrEn     = 1'b0;
    wrAddr   = ma;
    wrData   = aluRes;
    accEn    = 1'b0;
    accData  = aluRes;
    flagMask = 4'h0;
    pcLoad   = 1'b0;
    pcTarget = execIr[10:0];
    flushReq = 1'b0;
    push     = 1'b0;
    pop      = 1'b0;
    holdSet  = 1'b0;
    intEnSet = 1'b0;
    intEnClr = 1'b0;
    if (hold) begin
      wrEn   = 1'b1;
      wrAddr = tblDest;
      wrData = tblWord[7:0];
    end else begin
      case (opc)
        `CFS_OP_MISC: begin
          if (fn == `CFS_MS_RET || fn == `CFS_MS_INTERRUPT_EXIT) begin
            pop      = 1'b1;
            pcLoad   = 1'b1;
            pcTarget = stackChain[21:11];
            flushReq = 1'b1;
            intEnSet = (fn == `CFS_MS_INTERRUPT_EXIT);
          end
          intEnSet = intEnSet | (fn == `CFS_MS_EI);
          intEnClr = (fn == `CFS_MS_DI);
        end
        `CFS_OP_ALUA: begin
          accEn    = 1'b1;
          flagMask = aluMask;
        end
        `CFS_OP_ALUM: begin
          wrEn     = 1'b1;
          flagMask = aluMask;
        end
        `CFS_OP_SKIP: begin
          wrEn     = (fn == `CFS_SK_SIZ || fn == `CFS_SK_SDZ);
          accEn    = (fn == `CFS_SK_SIZA || fn == `CFS_SK_SDZA || fn == `CFS_SK_SZA);
          wrData   = stepVal;
          accData  = stepVal;
          flushReq = (fn == `CFS_SK_SNZ) ? (stepVal != 8'h00) : (stepVal == 8'h00);
        end
        `CFS_OP_MOVI: begin
          accEn   = 1'b1;
          accData = execIr[7:0];
        end
        `CFS_OP_JUMP: begin
          pcLoad   = 1'b1;
          flushReq = 1'b1;
        end
        `CFS_OP_CALL: begin
          push     = 1'b1;
          pcLoad   = 1'b1;
          flushReq = 1'b1;
        end
        `CFS_OP_TABRD: begin
          holdSet = 1'b1;
        end
        default: flushReq = 1'b0;
      endcase
    end
    if (wrEn && wrAddr == `CFS_DM_PCL) begin
      pcLoad   = 1'b1;
      pcTarget = {pcNext[10:8], wrData};
      flushReq = 1'b1;
    end
  end

  // data memory store
  always @(posedge clk) begin
    if (doExec && wrEn) begin
      dataMem[wrAddr] <= wrData;
    end
  end

  // program memory load from the bus
  always @(posedge clk) begin
    if (busWr && paddr == `CFS_OFF_PM_DATA) begin
      progMem[pmAddr] <= pwdata[14:0];
    end
  end

  // sequencer
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase       <= 2'h0;
      cyclePhases <= 4'h1;
      pc          <= `CFS_VEC_RESET;
      fetchIr     <= `CFS_NOP;
      execIr      <= `CFS_NOP;
      flush       <= 1'b0;
      hold        <= 1'b0;
      tblDest     <= 7'h00;
      tblLast     <= 1'b0;
      depth       <= 3'h0;
      acc         <= 8'h00;
      status      <= 4'h0;
      tblp        <= 8'h00;
      lookup_pointer_high        <= 3'h0;
      lookupHigh  <= 7'h00;
      intEnable   <= 1'b0;
      intFlag     <= 1'b0;
      intAck      <= 1'b0;
    end else if (restart) begin
      phase       <= 2'h0;
      cyclePhases <= 4'h1;
      pc          <= `CFS_VEC_RESET;
      fetchIr     <= `CFS_NOP;
      execIr      <= `CFS_NOP;
      flush       <= 1'b0;
      hold        <= 1'b0;
      depth       <= 3'h0;
      intEnable   <= 1'b0;
      intFlag     <= intReq;
      intAck      <= 1'b0;
    end else begin
      intFlag <= intReq | (intFlag & ~ackNow);
      intAck  <= ackNow;
      if (doStep) begin
        phase       <= phase + 2'h1;
        cyclePhases <= {cyclePhases[2:0], cyclePhases[3]};
      end
      if (doFetch) begin
        if (hold) begin
          execIr <= `CFS_NOP;
        end else begin
          execIr  <= flush ? `CFS_NOP : fetchIr;
          fetchIr <= progMem[pc];
          pc      <= pc + 11'h001;
          flush   <= 1'b0;
        end
      end
      if (doExec) begin
        hold    <= holdSet;
        tblDest <= holdSet ? ma : tblDest;
        tblLast <= holdSet ? fn[0] : tblLast;
        if (hold) begin
          lookupHigh <= tblWord[14:8];
        end
        if (ackNow) begin
          pc        <= `CFS_VEC_INT;
          flush     <= 1'b1;
          intEnable <= 1'b0;
        end else if (pcLoad) begin
          pc    <= pcTarget;
          flush <= 1'b1;
        end else if (flushReq) begin
          flush <= 1'b1;
        end
        if (intEnSet) begin
          intEnable <= 1'b1;
        end else if (intEnClr) begin
          intEnable <= 1'b0;
        end
        if (push || ackNow) begin
          depth <= stackFull ? depth : depth + 3'h1;
        end else if (pop && depth != 3'h0) begin
          depth <= depth - 3'h1;
        end
        if (accEn || (wrEn && wrAddr == `CFS_DM_ACC)) begin
          acc <= accEn ? accData : wrData;
        end
        if (wrEn && wrAddr == `CFS_DM_STATUS) begin
          status <= wrData[3:0];
        end else begin
          status <= (status & ~flagMask) | (aluFlags & flagMask);
        end
        if (wrEn && wrAddr == `CFS_DM_TBLP) begin
          tblp <= wrData;
        end
        if (wrEn && wrAddr == `CFS_DM_LOOKUP_POINTER_HIGH) begin
          lookup_pointer_high <= wrData[2:0];
        end
      end
    end
  end

  // register bus slave
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      runEn   <= 1'b0;
      restart <= 1'b0;
      pmAddr  <= 11'h000;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= 1'b1;
      restart <= busWr && paddr == `CFS_OFF_CTRL && pwdata[`CFS_CTRL_RESTART];
      if (busWr && paddr == `CFS_OFF_CTRL) begin
        runEn <= pwdata[`CFS_CTRL_RUN];
      end
      if (busWr && paddr == `CFS_OFF_PM_ADDR) begin
        pmAddr <= pwdata[10:0];
      end else if (busWr && paddr == `CFS_OFF_PM_DATA) begin
        pmAddr <= pmAddr + 11'h001;
      end
      if (busSetup) begin
        pslverr <= 1'b0;
        case (paddr)
          `CFS_OFF_CTRL:    prdata <= {31'h0000_0000, runEn};
          `CFS_OFF_PM_ADDR: prdata <= {21'h00_0000, pmAddr};
          `CFS_OFF_PM_DATA: prdata <= {17'h0_0000, progMem[pmAddr]};
          `CFS_OFF_STATE:   prdata <= {12'h000, intFlag, intEnable, phase,
                                       1'b0, depth, 1'b0, pc};
          `CFS_OFF_CORE:    prdata <= {pcNext[7:0], 1'b0, lookupHigh,
                                       4'h0, status, acc};
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule

// File: dv/cfs_seq_properties.sv
// Purpose: port-level checks for the fetch sequencer
// Assumes: core runs freely once started, never stopped mid-cycle
// Notes:   bound to every cfs_sequencer instance
`timescale 1ns/1ps
module cfs_seq_properties (
  // clock and reset
  input wire        clk,
  input wire        nrst,
  // register bus
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // interrupt and phases
  input wire        intReq,
  input wire        intAck,
  input wire [3:0]  cyclePhases
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_phase_onehot: assert property ($onehot(cyclePhases))
    else $error("phase view not one-hot");
  a_phase_rotate: assert property ($changed(cyclePhases) |->
    cyclePhases == {$past(cyclePhases[2:0]), $past(cyclePhases[3])})
    else $error("phase skipped or reversed");
  a_phase_runs_on: assert property (cyclePhases[0] ##1 cyclePhases[1] |=>
    cyclePhases[2] ##1 cyclePhases[3])
    else $error("instruction cycle cut short");
  a_ready_zero_wait: assert property (psel && !penable |=> pready)
    else $error("access phase not ready");
  a_err_unmapped: assert property (psel && !penable && paddr > 8'h10 |=>
    pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_read_stands: assert property (psel && penable |=> $stable(prdata))
    else $error("read data changed after access");
  a_ack_pulse: assert property (intAck |=> !intAck [*3])
    else $error("acknowledge longer than a pulse");
  a_ack_phase: assert property (intAck |->
    $past(cyclePhases[3]) || $past(cyclePhases[3], 2))
    else $error("acknowledge outside fourth phase");
endmodule

bind cfs_sequencer cfs_seq_properties u_props (
  .clk         (clk),
  .nrst        (nrst),
  .psel        (psel),
  .penable     (penable),
  .pwrite      (pwrite),
  .paddr       (paddr),
  .pwdata      (pwdata),
  .prdata      (prdata),
  .pready      (pready),
  .pslverr     (pslverr),
  .intReq      (intReq),
  .intAck      (intAck),
  .cyclePhases (cyclePhases)
);

// File: dv/cfs_pmem_model.sv
// Purpose: expected program memory image, 2K words of 15 bits
// Assumes: the bench copies it into the core over the register bus
// Notes:   unwritten words are no-ops
`timescale 1ns/1ps
module cfs_pmem_model;
  reg [14:0] mem [0:2047];
  integer    j;
  initial begin
    for (j = 0; j < 2048; j = j + 1) mem[j] = 15'h0000;
  end
  // program images start at word zero
  task put(input [10:0] a, input [14:0] w);
    mem[a] = w;
  endtask
endmodule

// File: dv/testbench.sv
// Purpose: self-checking bench for the fetch sequencer
// Assumes: programs loaded and inspected over the register bus
// Notes:   expected values come from a small model of the add path
`timescale 1ns/1ps
module testbench;
  // bus and pins
  reg         clk;
  reg         nrst;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata;
  reg         intReq;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        intAck;
  wire [3:0]  cyclePhases;
  // bench state
  integer     err_count;
  integer     compares;
  integer     cycles;
  integer     acks;
  integer     seed;
  integer     i;
  reg  [31:0] rd;
  reg         er;
  reg  [7:0]  r1;
  reg  [7:0]  r2;
  reg  [7:0]  k;
  reg  [14:0] dw;
  reg  [14:0] p1 [0:19];
  reg  [14:0] p2 [0:6];

  cfs_sequencer DUT (
    .clk         (clk),
    .nrst        (nrst),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .intReq      (intReq),
    .intAck      (intAck),
    .cyclePhases (cyclePhases)
  );
  cfs_pmem_model pm ();

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles = cycles + 1;
    if (intAck === 1'b1) acks = acks + 1;
    if (cycles > 20000) begin
      err_count = err_count + 1;
      end_sim;
    end
  end

  task end_sim;
    begin
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50) begin
        n = n + 1;
        @(posedge clk);
      end
      if (n >= 50) err_count = err_count + 1;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task load(input [10:0] a0, input [10:0] n);
    begin
      apb(1'b1, 8'h04, {21'h0, a0});
      for (i = 0; i < n; i = i + 1) apb(1'b1, 8'h08, {17'h0, pm.mem[a0 + i]});
      apb(1'b0, 8'h04, 32'h0000_0000);
      chk(rd[10:0], {21'h0, a0 + n});
      apb(1'b1, 8'h04, {21'h0, a0});
      apb(1'b0, 8'h08, 32'h0000_0000);
      chk(rd[14:0], pm.mem[a0]);
    end
  endtask

  // add model: {ov, z, ac, c, acc}
  function [11:0] addf(input [7:0] a, input [7:0] b);
    reg [8:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      addf[7:0] = s[7:0];
      addf[8] = s[8];
      addf[9] = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'd15;
      addf[10] = (s[7:0] == 8'h00);
      addf[11] = (a[7] == b[7]) && (s[7] != a[7]);
    end
  endfunction

  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    intReq = 1'b0;
    err_count = 0;
    compares = 0;
    cycles = 0;
    acks = 0;
    seed = 90;
    r1 = $random(seed) | 1;
    r2 = $random(seed);
    k = $random(seed);
    dw = $random(seed);
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(rd[11:0], 12'h000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    // page jump, add, call, last-page table read, taken skip, return
    p1 = '{15'h2800 | k, 15'h1787, 15'h280A, 15'h1786, 15'h3004, 0, 0, 0, 0, 0,
           15'h2800 | r1, 15'h17A0, 15'h2800 | r2, 15'h0820, 15'h3810, 15'h300F,
           15'h40A1, 15'h18A0, 15'h28FF, 15'h0080};
    for (i = 0; i < 20; i = i + 1) pm.put(i, p1[i]);
    pm.put({3'b111, k}, dw);
    load(11'h000, 11'd20);
    load({3'b111, k}, 11'd1);
    apb(1'b1, 8'h00, 32'h0000_0001);
    repeat (300) @(posedge clk);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(rd[11:0], addf(r2, r1));
    chk(rd[22:16], dw[14:8]);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk(rd[14:12], 3'd0);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(rd[22:16], dw[14:8]);
    // software restart: stop and return to the reset vector
    apb(1'b1, 8'h00, 32'h0000_0002);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    // five nested calls on a four-level stack
    nrst <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    p2 = '{15'h0180, 15'h3802, 15'h3803, 15'h3804, 15'h3805, 15'h3806, 15'h3006};
    for (i = 0; i < 7; i = i + 1) pm.put(i, p2[i]);
    load(11'h000, 11'd7);
    apb(1'b1, 8'h00, 32'h0000_0001);
    repeat (200) @(posedge clk);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk(rd[14:12], 3'd4);
    @(posedge clk);
    intReq <= 1'b1;
    @(posedge clk);
    intReq <= 1'b0;
    repeat (60) @(posedge clk);
    chk(acks, 0);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk(rd[19], 1'b1);
    apb(1'b1, 8'h04, 32'h0000_0006);
    apb(1'b1, 8'h08, 32'h0000_0080);
    for (i = 0; i < 400 && acks == 0; i = i + 1) @(posedge clk);
    chk(acks, 1);
    end_sim;
  end
endmodule
